/* verilog/dsu_device.sv */
// converter control end: serial decode, update strobes, toggle, fault
// Behaviour
// - shift data while select strobe low
// - strobe high: ignore clocks, run command
// - sample data-in on serial clock rise
// - frames of 24 or 32 bits
// - data-out changes on serial clock fall
// - data-out released while strobe high
// - update-strobe fall copies all, strobe high
// - update-strobe low: strobe rise copies all
// - serial commands also update outputs
// - toggle: fall loads A, rise loads B
// - dither: toggle pins clock, rise updates
// - only enabled channels follow toggle pins
// - unused toggling: enable zero, pins low
// - clear low: zero code, lowest span
// - clear also resets control registers
// - fault on overtemperature or link error
// - fault released at next strobe rise with no overtemperature and a good frame
// - fault pin open drain, pulls low
// - external reference releases reference pin
// - monitor disabled: monitor pin released
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dsu_device
  import dsu_pkg::*;
#(
  parameter int NCH = `DSU_NCH,
  parameter int CW  = `DSU_CODE_W
) (
  input  wire logic                         clock,
  input  wire logic                         nrst,
  dsu_link_if.device                        link,
  input  wire logic                         over_temp,
  output logic      [NCH*CW-1:0]            dac_codes,
  output logic      [NCH*`DSU_SPAN_W-1:0]   channel_spans,
  output logic      [NCH-1:0]               channel_toggle_enable,
  output logic                              dither_mode,
  output logic                              reference_comp_pin_oe_n,
  output logic                              mux_oe_n,
  output logic      [3:0]                   mux_select
);
  // synchronised pins: strobe, clock, data, update, clear, temp, toggles
  logic [8:0] pin_lvl;
  logic [8:0] pin_rise;
  logic [8:0] pin_fall;
  dsu_sync #(.W(9)) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({link.toggle_pins, over_temp, link.async_clear_n,
                link.async_update_strobe_n, link.sdi, link.sclk,
                link.select_load_strobe_n}),
    .rst_val  (9'h019),
    .level    (pin_lvl),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );
  logic       cs_lvl, cs_rise, cs_fall, sclk_rise, sclk_fall, sdi_lvl;
  logic       upd_lvl, upd_fall, clr_lvl, ot_lvl;
  logic [2:0] tgl_rise, tgl_fall;
  assign cs_lvl    = pin_lvl[0];
  assign cs_rise   = pin_rise[0];
  assign cs_fall   = pin_fall[0];
  assign sclk_rise = pin_rise[1];
  assign sclk_fall = pin_fall[1];
  assign sdi_lvl   = pin_lvl[2];
  assign upd_lvl   = pin_lvl[3];
  assign upd_fall  = pin_fall[3];
  assign clr_lvl   = pin_lvl[4];
  assign ot_lvl    = pin_lvl[5];
  assign tgl_rise  = pin_rise[8:6];
  assign tgl_fall  = pin_fall[8:6];

  // channel i follows toggle pin i mod 3
  function automatic logic [1:0] pin_of(input int ch);
    pin_of = 2'(ch % `DSU_NPIN);
  endfunction

  // link group
  logic [31:0] sr, next_sr, out_sr, next_out_sr, last, next_last;
  logic [5:0]  cnt, next_cnt;
  logic        sdo_q, next_sdo_q, sdo_oe_q, next_sdo_oe_q;
  logic        fault, next_fault;
  logic        frame_ok;
  always_comb begin
    next_sr       = sr;
    next_out_sr   = out_sr;
    next_last     = last;
    next_cnt      = cnt;
    next_sdo_q    = sdo_q;
    next_sdo_oe_q = sdo_oe_q;
    frame_ok      = 1'b0;
    if (cs_fall) begin
      next_cnt      = 6'h00;
      next_sdo_q    = last[31];
      next_out_sr   = {last[30:0], 1'b0};
      next_sdo_oe_q = 1'b0;
    end else if (!cs_lvl) begin
      if (sclk_rise) begin
        next_sr = {sr[30:0], sdi_lvl};
        if (cnt != `DSU_CNT_MAX)
          next_cnt = cnt + 6'h01;
      end
      if (sclk_fall) begin
        next_sdo_q  = out_sr[31];
        next_out_sr = {out_sr[30:0], 1'b0};
      end
    end
    if (cs_rise) begin
      next_sdo_oe_q = 1'b1;
      next_last     = sr;
      frame_ok      = (cnt == `DSU_FRAME_SHORT) ||
                      (cnt == `DSU_FRAME_LONG);
    end
    // a new error on the releasing edge keeps the flag low
    next_fault = (fault && !cs_rise) || ot_lvl ||
                 (cs_rise && !frame_ok);
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sr       <= 32'h0000_0000;
      out_sr   <= 32'h0000_0000;
      last     <= 32'h0000_0000;
      cnt      <= 6'h00;
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b1;
      fault    <= 1'b0;
    end else begin
      sr       <= next_sr;
      out_sr   <= next_out_sr;
      last     <= next_last;
      cnt      <= next_cnt;
      sdo_q    <= next_sdo_q;
      sdo_oe_q <= next_sdo_oe_q;
      fault    <= next_fault;
    end
  end

  // channel and control group
  logic [CW-1:0]          in_a [NCH], next_in_a [NCH];
  logic [CW-1:0]          in_b [NCH], next_in_b [NCH];
  logic [CW-1:0]          dac  [NCH], next_dac  [NCH];
  logic [`DSU_SPAN_W-1:0] span [NCH], next_span [NCH];
  logic [NCH-1:0]         phase, next_phase, en, next_en;
  logic                   ext_ref, next_ext_ref, mux_en, next_mux_en;
  logic                   dith, next_dith;
  logic [3:0]             msel, next_msel;
  dsu_cmd_t               cmd;
  logic [2:0]             ch;
  logic [CW-1:0]          dat;
  logic [1:0]             p;
  assign cmd = dsu_cmd_t'(sr[`DSU_CMD_MSB:`DSU_CMD_LSB]);
  assign ch  = sr[`DSU_ADDR_MSB:`DSU_ADDR_LSB];
  assign dat = sr[CW-1:0];
  always_comb begin
    next_in_a    = in_a;
    next_in_b    = in_b;
    next_dac     = dac;
    next_span    = span;
    next_phase   = phase;
    next_en      = en;
    next_ext_ref = ext_ref;
    next_mux_en  = mux_en;
    next_dith    = dith;
    next_msel    = msel;
    p            = 2'h0;
    if (frame_ok) begin
      unique case (cmd)
        DSU_CMD_WR_A:     next_in_a[ch] = dat;
        DSU_CMD_WR_B:     next_in_b[ch] = dat;
        DSU_CMD_WR_A_UPD: begin
          next_in_a[ch] = dat;
          next_dac[ch]  = dat;
        end
        DSU_CMD_UPD_CH:   next_dac[ch] = in_a[ch];
        DSU_CMD_UPD_ALL:  next_dac = in_a;
        DSU_CMD_WR_SPAN:  next_span[ch] = dat[`DSU_SPAN_W-1:0];
        DSU_CMD_WR_TGLEN: next_en = dat[NCH-1:0];
        DSU_CMD_WR_CFG: begin
          next_ext_ref = dat[`DSU_CFG_EXTREF];
          next_mux_en  = dat[`DSU_CFG_MUXEN];
          next_dith    = dat[`DSU_CFG_DITHER];
          next_msel    = dat[`DSU_CFG_MSEL_MSB:`DSU_CFG_MSEL_LSB];
        end
        default: ; // unknown codes are ignored
      endcase
    end
    // copies take the input registers as just written
    if ((upd_fall && cs_lvl) || (cs_rise && !upd_lvl))
      next_dac = next_in_a;
    for (int i = 0; i < NCH; i++) begin
      p = pin_of(i);
      if (en[i]) begin
        if (!dith) begin
          if (tgl_fall[p])
            next_dac[i] = next_in_a[i];
          else if (tgl_rise[p])
            next_dac[i] = next_in_b[i];
        end else if (tgl_rise[p]) begin
          next_phase[i] = !phase[i];
          next_dac[i]   = phase[i] ? next_in_a[i]
                                   : next_in_b[i];
        end
      end
    end
    if (!clr_lvl) begin
      for (int i = 0; i < NCH; i++) begin
        next_in_a[i] = `DSU_CODE_RST;
        next_in_b[i] = `DSU_CODE_RST;
        next_dac[i]  = `DSU_CODE_RST;
        next_span[i] = `DSU_SPAN_RST;
      end
      next_phase   = '0;
      next_en      = `DSU_EN_RST;
      next_ext_ref = 1'b0;
      next_mux_en  = 1'b0;
      next_dith    = 1'b0;
      next_msel    = `DSU_MSEL_RST;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        in_a[i] <= `DSU_CODE_RST;
        in_b[i] <= `DSU_CODE_RST;
        dac[i]  <= `DSU_CODE_RST;
        span[i] <= `DSU_SPAN_RST;
      end
      phase   <= '0;
      en      <= `DSU_EN_RST;
      ext_ref <= 1'b0;
      mux_en  <= 1'b0;
      dith    <= 1'b0;
      msel    <= `DSU_MSEL_RST;
    end else begin
      in_a    <= next_in_a;
      in_b    <= next_in_b;
      dac     <= next_dac;
      span    <= next_span;
      phase   <= next_phase;
      en      <= next_en;
      ext_ref <= next_ext_ref;
      mux_en  <= next_mux_en;
      dith    <= next_dith;
      msel    <= next_msel;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_out
      assign dac_codes[g*CW +: CW] = dac[g];
      assign channel_spans[g*`DSU_SPAN_W +: `DSU_SPAN_W] = span[g];
    end
  endgenerate
  assign channel_toggle_enable   = en;
  assign dither_mode             = dith;
  assign reference_comp_pin_oe_n = ext_ref;
  assign mux_oe_n                = !mux_en;
  assign mux_select              = msel;
  assign link.sdo_out            = sdo_q;
  assign link.sdo_oe_n           = sdo_oe_q;
  assign link.fault_out          = 1'b0;
  assign link.fault_oe_n         = !fault;
endmodule

/* verilog/dsu_cfg.svh */
// constants of the serial update link: fields, codes, resets, timing
`ifndef DSU_CFG_SVH
`define DSU_CFG_SVH
`define DSU_NCH          8
`define DSU_CODE_W       16
`define DSU_SPAN_W       3
`define DSU_NPIN         3
`define DSU_FRAME_SHORT  6'h18
`define DSU_FRAME_LONG   6'h20
`define DSU_CNT_MAX      6'h3f
`define DSU_CMD_MSB      23
`define DSU_CMD_LSB      20
`define DSU_ADDR_MSB     18
`define DSU_ADDR_LSB     16
`define DSU_DATA_MSB     15
`define DSU_CFG_EXTREF   0
`define DSU_CFG_MUXEN    1
`define DSU_CFG_DITHER   2
`define DSU_CFG_MSEL_LSB 4
`define DSU_CFG_MSEL_MSB 7
`define DSU_CODE_RST     16'h0000
`define DSU_SPAN_RST     3'h0
`define DSU_EN_RST       8'h00
`define DSU_MSEL_RST     4'h0
`define DSU_REG_TXWORD   4'h0
`define DSU_REG_CTRL     4'h1
`define DSU_REG_STATUS   4'h2
`define DSU_REG_RXWORD   4'h3
`define DSU_REG_PINS     4'h4
`define DSU_CTRL_GO      0
`define DSU_CTRL_LONG    1
`define DSU_PIN_UPD      0
`define DSU_PIN_CLR      1
`define DSU_PIN_TGL_LSB  2
`define DSU_PIN_TGL_MSB  4
`define DSU_PINS_RST     5'h03
`define DSU_CLK_HZ       10000000
`define DSU_SCLK_HALF_NS 800
`define DSU_SCLK_HALF_CYC \
  ((`DSU_SCLK_HALF_NS * (`DSU_CLK_HZ / 1000000) + 999) / 1000)
`endif

/* verilog/dsu_pkg.sv */
// types shared by both ends of the serial update link
package dsu_pkg;
  typedef enum logic [3:0] {
    DSU_CMD_WR_A     = 4'h0,
    DSU_CMD_WR_B     = 4'h1,
    DSU_CMD_WR_A_UPD = 4'h2,
    DSU_CMD_UPD_CH   = 4'h3,
    DSU_CMD_UPD_ALL  = 4'h4,
    DSU_CMD_WR_SPAN  = 4'h5,
    DSU_CMD_WR_TGLEN = 4'h6,
    DSU_CMD_WR_CFG   = 4'h7
  } dsu_cmd_t;
  typedef enum logic [2:0] {
    DSU_IDLE, DSU_LOW, DSU_HIGH, DSU_TAIL, DSU_GAP
  } dsu_host_state_t;
endpackage

/* verilog/dsu_link_if.sv */
// pins between the serial-link master and the converter control
`timescale 1ns/1ps
interface dsu_link_if;
  logic       select_load_strobe_n;
  logic       sclk;
  logic       sdi;
  logic       sdo_out;
  logic       sdo_oe_n;
  logic       sdo;
  logic       async_update_strobe_n;
  logic [2:0] toggle_pins;
  logic       async_clear_n;
  logic       fault_out;
  logic       fault_oe_n;
  logic       fault_n;
  // wire levels; fault has an external pull-up, released sdo reads low
  assign sdo     = !sdo_oe_n && sdo_out;
  assign fault_n = fault_oe_n ? 1'b1 : fault_out;
  modport device (
    input  select_load_strobe_n, sclk, sdi, async_update_strobe_n,
    input  toggle_pins, async_clear_n,
    output sdo_out, sdo_oe_n, fault_out, fault_oe_n
  );
  modport host (
    output select_load_strobe_n, sclk, sdi, async_update_strobe_n,
    output toggle_pins, async_clear_n,
    input  sdo, fault_n
  );
endinterface

/* verilog/dsu_sync.sv */
// two-flop synchroniser with edge pulses per bit
`timescale 1ns/1ps
module dsu_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;
  // levels wait two clocks, edges three: no false edge after reset
  logic [1:0]   arm;
  logic [1:0]   next_arm;
  assign next_arm = (arm == 2'h3) ? arm : arm + 2'h1;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta   <= '0;
      stable <= '0;
      prev   <= '0;
      arm    <= 2'h0;
    end else begin
      meta   <= async_in;
      stable <= meta;
      prev   <= stable;
      arm    <= next_arm;
    end
  end
  assign level = (arm >= 2'h2) ? stable : rst_val;
  assign rise  = (arm == 2'h3) ? (stable & ~prev) : '0;
  assign fall  = (arm == 2'h3) ? (~stable & prev) : '0;
endmodule

/* verilog/dsu_host.sv */
// serial-link master: sends frames, drives strobe and toggle pins
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dsu_host
  import dsu_pkg::*;
#(
  parameter int HALF = `DSU_SCLK_HALF_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  dsu_link_if.host         link,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata
);
  logic [1:0] in_lvl;
  dsu_sync #(.W(2)) u_sync (
    .clock    (clock),
    .nrst     (nrst),
    .async_in ({link.fault_n, link.sdo}),
    .rst_val  (2'h2),
    .level    (in_lvl),
    .rise     (),
    .fall     ()
  );
  dsu_host_state_t st, next_st;
  logic [31:0] tx, next_tx, sh, next_sh, rx, next_rx, rxw, next_rxw;
  logic [31:0] rdq, next_rdq;
  logic [4:0]  pins, next_pins;
  logic [5:0]  bits, next_bits;
  logic [7:0]  tmr, next_tmr;
  logic        cs, next_cs, sck, next_sck, sdi, next_sdi;
  logic        half_done;
  assign half_done = (tmr == 8'(HALF - 1));
  always_comb begin
    next_st   = st;
    next_tx   = tx;
    next_sh   = sh;
    next_rx   = rx;
    next_rxw  = rxw;
    next_pins = pins;
    next_bits = bits;
    next_tmr  = half_done ? 8'h00 : tmr + 8'h01;
    next_cs   = cs;
    next_sck  = sck;
    next_sdi  = sdi;
    next_rdq  = 32'h0000_0000;
    if (wr && addr == `DSU_REG_TXWORD)
      next_tx = wdata;
    if (wr && addr == `DSU_REG_PINS)
      next_pins = wdata[4:0];
    if (rd) begin
      unique case (addr)
        `DSU_REG_TXWORD: next_rdq = tx;
        `DSU_REG_STATUS: next_rdq = {30'h0, !in_lvl[1], st != DSU_IDLE};
        `DSU_REG_RXWORD: next_rdq = rxw;
        `DSU_REG_PINS:   next_rdq = {27'h0, pins};
        default:         next_rdq = 32'h0000_0000;
      endcase
    end
    unique case (st)
      DSU_IDLE: begin
        next_tmr = 8'h00;
        // a go while busy is ignored
        if (wr && addr == `DSU_REG_CTRL && wdata[`DSU_CTRL_GO]) begin
          next_sh   = wdata[`DSU_CTRL_LONG] ? tx : {tx[23:0], 8'h00};
          next_bits = wdata[`DSU_CTRL_LONG] ? `DSU_FRAME_LONG
                                            : `DSU_FRAME_SHORT;
          next_sdi  = wdata[`DSU_CTRL_LONG] ? tx[31] : tx[23];
          next_cs   = 1'b0;
          next_rx   = 32'h0000_0000;
          next_st   = DSU_LOW;
        end
      end
      DSU_LOW: if (half_done) begin
        next_sck = 1'b1;
        next_rx  = {rx[30:0], in_lvl[0]};
        next_st  = DSU_HIGH;
      end
      DSU_HIGH: if (half_done) begin
        next_sck  = 1'b0;
        next_bits = bits - 6'h01;
        next_sh   = {sh[30:0], 1'b0};
        next_sdi  = sh[30];
        next_st   = (bits == 6'h01) ? DSU_TAIL : DSU_LOW;
      end
      DSU_TAIL: if (half_done) begin
        next_cs  = 1'b1;
        next_rxw = rx;
        next_st  = DSU_GAP;
      end
      DSU_GAP: if (half_done)
        next_st = DSU_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st   <= DSU_IDLE;
      tx   <= 32'h0000_0000;
      sh   <= 32'h0000_0000;
      rx   <= 32'h0000_0000;
      rxw  <= 32'h0000_0000;
      rdq  <= 32'h0000_0000;
      pins <= `DSU_PINS_RST;
      bits <= 6'h00;
      tmr  <= 8'h00;
      cs   <= 1'b1;
      sck  <= 1'b0;
      sdi  <= 1'b0;
    end else begin
      st   <= next_st;
      tx   <= next_tx;
      sh   <= next_sh;
      rx   <= next_rx;
      rxw  <= next_rxw;
      rdq  <= next_rdq;
      pins <= next_pins;
      bits <= next_bits;
      tmr  <= next_tmr;
      cs   <= next_cs;
      sck  <= next_sck;
      sdi  <= next_sdi;
    end
  end
  assign rdata                      = rdq;
  assign link.select_load_strobe_n  = cs;
  assign link.sclk                  = sck;
  assign link.sdi                   = sdi;
  assign link.async_update_strobe_n = pins[`DSU_PIN_UPD];
  assign link.async_clear_n         = pins[`DSU_PIN_CLR];
  assign link.toggle_pins = pins[`DSU_PIN_TGL_MSB:`DSU_PIN_TGL_LSB];
endmodule

/* verification/dsu_link_sva.sv */
// link-level checks on the pins between host and converter control
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dsu_link_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic select_load_strobe_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic fault_out,
  input wire logic fault_oe_n
);
  logic [5:0] rise_cnt;
  logic [5:0] next_rise_cnt;
  logic       sclk_q;
  // counts serial clock rises inside one frame, saturating
  always_comb begin
    next_rise_cnt = rise_cnt;
    if (select_load_strobe_n)
      next_rise_cnt = 6'h00;
    else if (sclk && !sclk_q && rise_cnt != `DSU_CNT_MAX)
      next_rise_cnt = rise_cnt + 6'h01;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rise_cnt <= 6'h00;
      sclk_q   <= 1'b0;
    end else begin
      rise_cnt <= next_rise_cnt;
      sclk_q   <= sclk;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // sync delay of three clocks leaves the first cycles out
  chk_sdo_released: assert property (
    select_load_strobe_n [*5] |-> sdo_oe_n)
    else $error("sdo driven while deselected");
  chk_sdo_driven: assert property (
    !select_load_strobe_n [*5] |-> !sdo_oe_n)
    else $error("sdo not driven inside frame");
  chk_sdo_on_fall: assert property (
    !sdo_oe_n && $past(!sdo_oe_n) && $changed(sdo_out) |-> !$past(sclk, 2))
    else $error("sdo changed after a rising edge");
  chk_fault_low_only: assert property (
    !fault_oe_n |-> !fault_out)
    else $error("fault pin driven high");
  chk_fault_release: assert property (
    $rose(fault_oe_n) |->
      select_load_strobe_n && !$past(select_load_strobe_n, 8))
    else $error("fault released without strobe rise");
  chk_sclk_framed: assert property (
    $rose(sclk) |-> !select_load_strobe_n)
    else $error("serial clock rose outside frame");
  chk_sdi_steady: assert property (
    $rose(sclk) |-> $stable(sdi))
    else $error("data-in moved at clock rise");
  chk_frame_len: assert property (
    $rose(select_load_strobe_n) |->
      rise_cnt == `DSU_FRAME_SHORT || rise_cnt == `DSU_FRAME_LONG)
    else $error("frame length not 24 or 32");
  chk_sclk_idle: assert property (
    select_load_strobe_n |-> !sclk)
    else $error("serial clock high while deselected");
endmodule

/* verification/dac_serial_update_control_tb.sv */
// bench: host register port drives frames into the converter control
`timescale 1ns/1ps
`include "dsu_cfg.svh"
module dac_serial_update_control_tb
  import dsu_pkg::*;
;
  logic         clock;
  logic         nrst;
  logic [3:0]   h_addr;
  logic [31:0]  h_wdata;
  logic         h_wr;
  logic         h_rd;
  logic [31:0]  h_rdata;
  logic         ot;
  logic [127:0] codes;
  logic [127:0] codes2;
  logic [23:0]  spans;
  logic [7:0]   ten;
  logic         dith;
  logic         ref_oe_n;
  logic         mux_oe_n;
  logic [3:0]   msel;
  logic [31:0]  v;
  logic [31:0]  w;
  int           errors;
  int           samples_checked;
  dsu_link_if link ();
  dsu_link_if link2 ();
  dsu_host dsu_host_inst (.clock(clock), .nrst(nrst), .link(link.host),
    .addr(h_addr), .wdata(h_wdata), .wr(h_wr), .rd(h_rd), .rdata(h_rdata));
  dsu_device dsu_device_inst (.clock(clock), .nrst(nrst),
    .link(link.device), .over_temp(ot), .dac_codes(codes),
    .channel_spans(spans), .channel_toggle_enable(ten), .dither_mode(dith),
    .reference_comp_pin_oe_n(ref_oe_n), .mux_oe_n(mux_oe_n),
    .mux_select(msel));
  // second end faces a hand-driven link that breaks the frame length
  dsu_device dsu_device_inst2 (.clock(clock), .nrst(nrst),
    .link(link2.device), .over_temp(1'b0), .dac_codes(codes2),
    .channel_spans(), .channel_toggle_enable(), .dither_mode(),
    .reference_comp_pin_oe_n(), .mux_oe_n(), .mux_select());
  dsu_link_sva dsu_link_sva_inst (.clock(clock), .nrst(nrst),
    .select_load_strobe_n(link.select_load_strobe_n), .sclk(link.sclk),
    .sdi(link.sdi), .sdo_out(link.sdo_out), .sdo_oe_n(link.sdo_oe_n),
    .fault_out(link.fault_out), .fault_oe_n(link.fault_oe_n));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    h_addr  <= a;
    h_wdata <= d;
    h_wr    <= 1'b1;
    @(posedge clock);
    h_wr    <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    h_addr <= a;
    h_rd   <= 1'b1;
    @(posedge clock);
    h_rd   <= 1'b0;
    #1 d = h_rdata;
  endtask
  // busy polled under a bound; a hung frame fails the idle check
  task send(input logic [31:0] fw, input logic lng);
    logic [31:0] s;
    int          i;
    wr(`DSU_REG_TXWORD, fw);
    wr(`DSU_REG_CTRL, {30'h0000_0000, lng, 1'b1});
    s = 32'h0000_0001;
    for (i = 0; i < 400 && s[0] === 1'b1; i++)
      rd(`DSU_REG_STATUS, s);
    check(s[0], 1'b0);
    repeat (6) @(posedge clock);
  endtask
  task pins(input logic [31:0] p);
    wr(`DSU_REG_PINS, p);
    repeat (6) @(posedge clock);
  endtask
  function automatic logic [31:0] cw(input logic [3:0] c,
    input logic [2:0] ch, input logic [15:0] d);
    return {8'h00, c, 1'b0, ch, d};
  endfunction
  // cut frame of 25 bits that carries a valid write-and-update command
  task bad_frame(input logic [31:0] fw);
    logic [31:0] s;
    int          i;
    s = fw << 7;
    @(posedge clock);
    link2.select_load_strobe_n <= 1'b0;
    link2.sdi                  <= s[31];
    for (i = 0; i < 25; i++) begin
      repeat (4) @(posedge clock);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge clock);
      link2.sclk <= 1'b0;
      s = s << 1;
      link2.sdi  <= s[31];
    end
    repeat (4) @(posedge clock);
    link2.select_load_strobe_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    stop_test;
  end
  initial begin
    nrst = 1'b0; h_addr = 4'h0; h_wdata = 32'h0000_0000;
    h_wr = 1'b0; h_rd = 1'b0; ot = 1'b0; errors = 0; samples_checked = 0;
    link2.select_load_strobe_n = 1'b1; link2.sclk = 1'b0; link2.sdi = 1'b0;
    link2.async_update_strobe_n = 1'b1; link2.toggle_pins = 3'h0;
    link2.async_clear_n = 1'b1;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    check(ref_oe_n, 1'b0);
    check(mux_oe_n, 1'b1);
    check(link.sdo_oe_n, 1'b1);
    check(link.fault_n, 1'b1);
    send(cw(DSU_CMD_WR_A, 3'h2, 16'h1234), 1'b0);
    check(codes[32+:16], 16'h0000);
    send(cw(DSU_CMD_UPD_CH, 3'h2, 16'h0000), 1'b0);
    check(codes[32+:16], 16'h1234);
    w = cw(DSU_CMD_WR_A_UPD, 3'h5, 16'hbeef) | 32'haa00_0000;
    send(w, 1'b1);
    check(codes[80+:16], 16'hbeef);
    send(cw(DSU_CMD_WR_SPAN, 3'h4, 16'h0003), 1'b1);
    check(spans[12+:3], 3'h3);
    rd(`DSU_REG_RXWORD, v);
    check(v, w);
    send(cw(DSU_CMD_WR_A, 3'h1, 16'h0101), 1'b0);
    pins(32'h0000_0002);
    check(codes[16+:16], 16'h0101);
    send(cw(DSU_CMD_WR_A, 3'h1, 16'h0202), 1'b0);
    check(codes[16+:16], 16'h0202);
    pins(32'h0000_0003);
    send(cw(DSU_CMD_WR_B, 3'h0, 16'h00bb), 1'b0);
    send(cw(DSU_CMD_WR_B, 3'h3, 16'h0033), 1'b0);
    send(cw(DSU_CMD_WR_A, 3'h0, 16'h00aa), 1'b0);
    send(cw(DSU_CMD_WR_TGLEN, 3'h0, 16'h0001), 1'b0);
    pins(32'h0000_0007);
    check(codes[0+:16], 16'h00bb);
    check(codes[48+:16], 16'h0000);
    pins(32'h0000_0003);
    check(codes[0+:16], 16'h00aa);
    send(cw(DSU_CMD_WR_CFG, 3'h0, 16'h0097), 1'b0);
    check(dith, 1'b1);
    check(ref_oe_n, 1'b1);
    check({mux_oe_n, msel}, 5'h09);
    pins(32'h0000_0007);
    check(codes[0+:16], 16'h00bb);
    pins(32'h0000_0003);
    check(codes[0+:16], 16'h00bb);
    pins(32'h0000_0007);
    check(codes[0+:16], 16'h00aa);
    pins(32'h0000_0003);
    send(cw(DSU_CMD_WR_CFG, 3'h0, 16'h0000), 1'b0);
    check({ref_oe_n, mux_oe_n}, 2'h1);
    send(cw(DSU_CMD_WR_TGLEN, 3'h0, 16'h0000), 1'b0);
    send(cw(DSU_CMD_WR_A, 3'h6, 16'h0666), 1'b0);
    check(codes[96+:16], 16'h0000);
    @(posedge clock);
    ot <= 1'b1;
    repeat (6) @(posedge clock);
    check(link.fault_n, 1'b0);
    rd(`DSU_REG_STATUS, v);
    check(v, 32'h0000_0002);
    ot <= 1'b0;
    repeat (6) @(posedge clock);
    check(link.fault_n, 1'b0);
    send(cw(DSU_CMD_UPD_ALL, 3'h0, 16'h0000), 1'b0);
    check(link.fault_n, 1'b1);
    check(codes[96+:16], 16'h0666);
    send(cw(DSU_CMD_WR_TGLEN, 3'h0, 16'h00ff), 1'b0);
    send(cw(DSU_CMD_WR_CFG, 3'h0, 16'h0004), 1'b0);
    pins(32'h0000_0001);
    check(|codes, 1'b0);
    check(|spans, 1'b0);
    check({ten, dith}, 9'h000);
    pins(32'h0000_0003);
    bad_frame(cw(DSU_CMD_WR_A_UPD, 3'h0, 16'h1111));
    check(link2.fault_n, 1'b0);
    check(|codes2, 1'b0);
    check(link2.sdo_oe_n, 1'b1);
    stop_test;
  end
endmodule
